// >>> design/bcce_defs.vh
`ifndef BCCE_DEFS_VH
`define BCCE_DEFS_VH

`define BCCE_OP_BR_OVF     8'hE4
`define BCCE_OP_BR_ZERO    8'hE0
`define BCCE_OP_CALL       7'h76
`define BCCE_OP_CLR_FILE   7'h35
`define BCCE_OP_CLR_WDOG   16'h0004

`define BCCE_PC_W          21
`define BCCE_PC_STEP       21'h000002
`define BCCE_PC_RESET      21'h000000
`define BCCE_RET_STEP      21'h000002

`define BCCE_ST_N          4
`define BCCE_ST_OV         3
`define BCCE_ST_Z          2
`define BCCE_STATUS_W      5
`define BCCE_STATUS_RESET  5'h00

`define BCCE_INDEX_MAX     8'h5F
`define BCCE_ACC_LOW_BANK  4'h0
`define BCCE_ACC_HIGH_BANK 4'hF
`define BCCE_CLEAR_VALUE   8'h00

`define BCCE_RA_CTRL       4'h0
`define BCCE_RA_W          4'h1
`define BCCE_RA_STATUS     4'h2
`define BCCE_RA_BANK       4'h3
`define BCCE_RA_WSHAD      4'h4
`define BCCE_RA_STSHAD     4'h5
`define BCCE_RA_BKSHAD     4'h6
`define BCCE_RA_PC         4'h7
`define BCCE_RA_RSTOP      4'h8
`define BCCE_RA_STKPTR     4'h9
`define BCCE_RA_WDSTAT     4'hA
`define BCCE_RA_WDCNT      4'hB

`define BCCE_CTRL_EXT      0
`define BCCE_WDS_TMO       0
`define BCCE_WDS_PWD       1

`endif

// >>> design/bcce_watchdog.v
`timescale 1ns/10ps
module bcce_watchdog #(
    parameter CNT_W  = 8,
    parameter POST_W = 4
) (
    clk_sys,       // Core clock.
    sys_rst,       // Synchronous reset, active high.
    clearReq,      // Clears counter and postscaler.
    countVal,      // Current counter value.
    postVal,       // Current postscaler value.
    timeoutPulse   // One cycle when postscaler wraps.
);
    input  wire              clk_sys;
    input  wire              sys_rst;
    input  wire              clearReq;
    output wire [CNT_W-1:0]  countVal;
    output wire [POST_W-1:0] postVal;
    output reg               timeoutPulse;

    reg  [CNT_W-1:0]  countQ;
    reg  [POST_W-1:0] postQ;
    wire              countWrap;
    wire              postWrap;

    assign countWrap = &countQ;
    assign postWrap  = &postQ;
    assign countVal  = countQ;
    assign postVal   = postQ;

    always @(posedge clk_sys) begin
        if (sys_rst || clearReq) begin
            countQ       <= {CNT_W{1'b0}};
            postQ        <= {POST_W{1'b0}};
            timeoutPulse <= 1'b0;
        end else begin
            countQ       <= countQ + {{(CNT_W-1){1'b0}}, 1'b1};
            timeoutPulse <= countWrap & postWrap;
            if (countWrap) begin
                postQ <= postQ + {{(POST_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// >>> design/bcce_core.v
`timescale 1ns/10ps
`include "bcce_defs.vh"
module bcce_core #(
    parameter STACK_DEPTH = 31,
    parameter STACK_PTR_W = 5,
    parameter WD_CNT_W    = 8,
    parameter WD_POST_W   = 4
) (
    clk_sys,       // Core clock, four per instruction cycle.
    sys_rst,       // Synchronous reset, active high.
    regAddr,       // Register port address.
    regWdata,      // Register port write data.
    regWr,         // Register write strobe.
    regRd,         // Register read strobe.
    regRdata,      // Register read data, one cycle after strobe.
    progAddr,      // Program fetch address.
    fetchStrobe,   // High in Q1 while a word is fetched.
    instrWord,     // Instruction word at progAddr.
    instrWord2,    // Instruction word at progAddr plus two.
    dataAddr,      // Data memory address.
    dataRd,        // Data memory read strobe.
    dataWr,        // Data memory write strobe.
    dataWdata,     // Data memory write data.
    indexedMode,   // Current operand uses indexed literal offset.
    fsr2Base,      // Base pointer for indexed literal offset.
    sleepEntry,    // Pulse from power control entering sleep.
    timeoutFlag,   // Active-low watchdog timeout status.
    powerdownFlag, // Active-low power-down status.
    wdogTimeout    // One-cycle watchdog timeout pulse.
);
    input  wire                    clk_sys;
    input  wire                    sys_rst;
    input  wire [3:0]              regAddr;
    input  wire [31:0]             regWdata;
    input  wire                    regWr;
    input  wire                    regRd;
    output reg  [31:0]             regRdata;
    output wire [`BCCE_PC_W-1:0]   progAddr;
    output wire                    fetchStrobe;
    input  wire [15:0]             instrWord;
    input  wire [15:0]             instrWord2;
    output reg  [11:0]             dataAddr;
    output wire                    dataRd;
    output wire                    dataWr;
    output reg  [7:0]              dataWdata;
    output reg                     indexedMode;
    input  wire [11:0]             fsr2Base;
    input  wire                    sleepEntry;
    output wire                    timeoutFlag;
    output wire                    powerdownFlag;
    output wire                    wdogTimeout;

    localparam [3:0] PH_Q1 = 4'h1;
    localparam [3:0] PH_Q2 = 4'h2;
    localparam [3:0] PH_Q3 = 4'h4;
    localparam [3:0] PH_Q4 = 4'h8;

    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_NOP  = 2'h2;

    reg  [3:0]                   phaseQ;
    reg  [3:0]                   phaseD;
    reg  [1:0]                   stateQ;
    reg  [1:0]                   stateD;
    reg  [`BCCE_PC_W-1:0]        pcQ;
    reg  [15:0]                  instrQ;
    reg  [15:0]                  instr2Q;
    reg  [7:0]                   wregQ;
    reg  [`BCCE_STATUS_W-1:0]    statusQ;
    reg  [3:0]                   bankSelQ;
    reg  [7:0]                   wShadowQ;
    reg  [`BCCE_STATUS_W-1:0]    statusShadowQ;
    reg  [3:0]                   bankSelShadowQ;
    reg                          extEnableQ;
    reg                          timeoutFlagQ;
    reg                          powerdownFlagQ;
    reg  [`BCCE_PC_W-1:0]        stackMem [0:STACK_DEPTH-1];
    reg  [STACK_PTR_W-1:0]       stackPtrQ;
    reg  [`BCCE_PC_W-1:0]        topOfReturnStack;

    wire                         execValid;
    wire                         isBranchOnOverflow;
    wire                         isBranchOnZero;
    wire                         isCall;
    wire                         isClearFileRegister;
    wire                         isClearWatchdog;
    wire                         branchTaken;
    wire [`BCCE_PC_W-1:0]        branchTarget;
    wire [`BCCE_PC_W-1:0]        callTarget;
    wire [`BCCE_PC_W-1:0]        returnAddr;
    wire [19:0]                  callLiteral;
    wire                         fastSave;
    wire                         stackFull;
    wire                         wdClear;
    wire [WD_CNT_W-1:0]          wdCount;
    wire [WD_POST_W-1:0]         wdPost;

    // Operand addressing inputs taken from the word being fetched.
    wire [7:0]                   fetchFile;
    wire                         fetchAccess;
    wire                         fetchIsClear;
    reg  [11:0]                  fetchAddr;
    reg                          fetchIndexed;

    assign execValid           = (stateQ == ST_EXEC);
    assign isBranchOnOverflow  = execValid && (instrQ[15:8] == `BCCE_OP_BR_OVF);
    assign isBranchOnZero      = execValid && (instrQ[15:8] == `BCCE_OP_BR_ZERO);
    assign isCall              = execValid && (instrQ[15:9] == `BCCE_OP_CALL);
    assign isClearFileRegister = execValid && (instrQ[15:9] == `BCCE_OP_CLR_FILE);
    assign isClearWatchdog     = execValid && (instrQ == `BCCE_OP_CLR_WDOG);

    assign branchTaken = (isBranchOnOverflow && statusQ[`BCCE_ST_OV])
                       || (isBranchOnZero && statusQ[`BCCE_ST_Z]);

    // Offset is sign-extended and doubled; pcQ already points past the branch.
    assign branchTarget = pcQ + {{12{instrQ[7]}}, instrQ[7:0], 1'b0};

    assign callLiteral = {instr2Q[11:0], instrQ[7:0]};
    assign callTarget  = {callLiteral, 1'b0};
    assign returnAddr  = pcQ + `BCCE_RET_STEP;
    assign fastSave    = instrQ[8];

    assign stackFull   = (stackPtrQ == STACK_DEPTH[STACK_PTR_W-1:0]);

    assign progAddr    = pcQ;
    assign fetchStrobe = (phaseQ == PH_Q1) && execValid;
    assign dataRd      = isClearFileRegister && (phaseQ == PH_Q2);
    assign dataWr      = isClearFileRegister && (phaseQ == PH_Q4);

    assign fetchFile   = instrWord[7:0];
    assign fetchAccess = instrWord[8];
    assign fetchIsClear = (instrWord[15:9] == `BCCE_OP_CLR_FILE);

    assign wdClear       = isClearWatchdog && (phaseQ == PH_Q3);
    assign timeoutFlag   = timeoutFlagQ;
    assign powerdownFlag = powerdownFlagQ;

    always @* begin
        fetchIndexed = 1'b0;
        if (!fetchAccess) begin
            if (extEnableQ && (fetchFile <= `BCCE_INDEX_MAX)) begin
                fetchIndexed = 1'b1;
                fetchAddr    = fsr2Base + {4'h0, fetchFile};
            end else if (fetchFile <= `BCCE_INDEX_MAX) begin
                fetchAddr = {`BCCE_ACC_LOW_BANK, fetchFile};
            end else begin
                fetchAddr = {`BCCE_ACC_HIGH_BANK, fetchFile};
            end
        end else begin
            fetchAddr = {bankSelQ, fetchFile};
        end
    end

    always @* begin
        case (phaseQ)
            PH_Q1:   phaseD = PH_Q2;
            PH_Q2:   phaseD = PH_Q3;
            PH_Q3:   phaseD = PH_Q4;
            PH_Q4:   phaseD = PH_Q1;
            default: phaseD = PH_Q1;
        endcase
    end

    always @* begin
        stateD = stateQ;
        case (stateQ)
            ST_EXEC: begin
                if ((phaseQ == PH_Q4) && (branchTaken || isCall)) begin
                    stateD = ST_NOP;
                end
            end
            ST_NOP: begin
                if (phaseQ == PH_Q4) begin
                    stateD = ST_EXEC;
                end
            end
            default: stateD = ST_EXEC;
        endcase
    end

    always @* begin
        if (stackPtrQ == {STACK_PTR_W{1'b0}}) begin
            topOfReturnStack = `BCCE_PC_RESET;
        end else begin
            topOfReturnStack = stackMem[stackPtrQ - {{(STACK_PTR_W-1){1'b0}}, 1'b1}];
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            phaseQ <= PH_Q1;
            stateQ <= ST_EXEC;
        end else begin
            phaseQ <= phaseD;
            stateQ <= stateD;
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pcQ         <= `BCCE_PC_RESET;
            instrQ      <= 16'h0000;
            instr2Q     <= 16'h0000;
            dataAddr    <= 12'h000;
            dataWdata   <= `BCCE_CLEAR_VALUE;
            indexedMode <= 1'b0;
        end else begin
            if (fetchStrobe) begin
                instrQ      <= instrWord;
                instr2Q     <= instrWord2;
                pcQ         <= pcQ + `BCCE_PC_STEP;
                dataAddr    <= fetchAddr;
                indexedMode <= fetchIndexed && fetchIsClear;
                dataWdata   <= `BCCE_CLEAR_VALUE;
            end else if (phaseQ == PH_Q4) begin
                if (branchTaken) begin
                    pcQ <= branchTarget;
                end else if (isCall) begin
                    pcQ <= callTarget;
                end
            end
            if (stateQ == ST_NOP) begin
                indexedMode <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            stackPtrQ <= {STACK_PTR_W{1'b0}};
        end else if (isCall && (phaseQ == PH_Q3) && !stackFull) begin
            stackPtrQ <= stackPtrQ + {{(STACK_PTR_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys) begin
        if (isCall && (phaseQ == PH_Q3) && !stackFull) begin
            stackMem[stackPtrQ] <= returnAddr;
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wShadowQ       <= 8'h00;
            statusShadowQ  <= `BCCE_STATUS_RESET;
            bankSelShadowQ <= 4'h0;
        end else if (isCall && fastSave && (phaseQ == PH_Q3)) begin
            wShadowQ       <= wregQ;
            statusShadowQ  <= statusQ;
            bankSelShadowQ <= bankSelQ;
        end
    end

    // Bus writes land first; the core's zero-flag update overrides them.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            wregQ      <= 8'h00;
            statusQ    <= `BCCE_STATUS_RESET;
            bankSelQ   <= 4'h0;
            extEnableQ <= 1'b0;
        end else begin
            if (regWr) begin
                case (regAddr)
                    `BCCE_RA_CTRL:   extEnableQ <= regWdata[`BCCE_CTRL_EXT];
                    `BCCE_RA_W:      wregQ      <= regWdata[7:0];
                    `BCCE_RA_STATUS: statusQ    <= regWdata[`BCCE_STATUS_W-1:0];
                    `BCCE_RA_BANK:   bankSelQ   <= regWdata[3:0];
                    default:         extEnableQ <= extEnableQ;
                endcase
            end
            if (dataWr) begin
                statusQ[`BCCE_ST_Z] <= 1'b1;
            end
        end
    end

    // A watchdog clear outranks a timeout or a sleep entry in the same cycle.
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            timeoutFlagQ   <= 1'b1;
            powerdownFlagQ <= 1'b1;
        end else if (wdClear) begin
            timeoutFlagQ   <= 1'b1;
            powerdownFlagQ <= 1'b1;
        end else begin
            if (wdogTimeout) begin
                timeoutFlagQ <= 1'b0;
            end
            if (sleepEntry) begin
                powerdownFlagQ <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                `BCCE_RA_CTRL:    regRdata <= {31'h00000000, extEnableQ};
                `BCCE_RA_W:       regRdata <= {24'h000000, wregQ};
                `BCCE_RA_STATUS:  regRdata <= {27'h0000000, statusQ};
                `BCCE_RA_BANK:    regRdata <= {28'h0000000, bankSelQ};
                `BCCE_RA_WSHAD:   regRdata <= {24'h000000, wShadowQ};
                `BCCE_RA_STSHAD:  regRdata <= {27'h0000000, statusShadowQ};
                `BCCE_RA_BKSHAD:  regRdata <= {28'h0000000, bankSelShadowQ};
                `BCCE_RA_PC:      regRdata <= {11'h000, pcQ};
                `BCCE_RA_RSTOP:   regRdata <= {11'h000, topOfReturnStack};
                `BCCE_RA_STKPTR:  regRdata <= {{(32-STACK_PTR_W){1'b0}}, stackPtrQ};
                `BCCE_RA_WDSTAT:  regRdata <= {30'h00000000, powerdownFlagQ, timeoutFlagQ};
                `BCCE_RA_WDCNT:   regRdata <= {{(32-WD_CNT_W-WD_POST_W){1'b0}}, wdPost, wdCount};
                default:          regRdata <= 32'h00000000;
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    bcce_watchdog #(
        .CNT_W  (WD_CNT_W),
        .POST_W (WD_POST_W)
    ) u_watchdog (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .clearReq     (wdClear),
        .countVal     (wdCount),
        .postVal      (wdPost),
        .timeoutPulse (wdogTimeout)
    );
endmodule

// >>> dv/bcce_core_props.sv
`timescale 1ns/10ps
module bcce_core_props #(
    parameter WD_CNT_W  = 8,
    parameter WD_POST_W = 4
) (
    input logic        clk_sys,       // Clock.
    input logic        sys_rst,       // Reset.
    input logic [3:0]  regAddr,       // Reg address.
    input logic [31:0] regWdata,      // Reg data in.
    input logic        regWr,         // Reg write.
    input logic        regRd,         // Reg read.
    input logic [31:0] regRdata,      // Reg data out.
    input logic [20:0] progAddr,      // Fetch address.
    input logic        fetchStrobe,   // Fetch strobe.
    input logic [15:0] instrWord,     // First word.
    input logic [15:0] instrWord2,    // Second word.
    input logic [11:0] dataAddr,      // Data address.
    input logic        dataRd,        // Data read.
    input logic        dataWr,        // Data write.
    input logic [7:0]  dataWdata,     // Data value.
    input logic        indexedMode,   // Indexed operand.
    input logic [11:0] fsr2Base,      // Indexed base.
    input logic        sleepEntry,    // Sleep pulse.
    input logic        timeoutFlag,   // Timeout, low.
    input logic        powerdownFlag, // Power-down, low.
    input logic        wdogTimeout    // Timeout pulse.
);
    // Mirrors of the flags and bank that software writes over the register port.
    logic        ov_q, z_q, ext_q;
    logic [3:0]  bank_q;
    wire  [7:0]  fLit    = instrWord[7:0];
    wire         fLow    = fLit <= 8'h5F;
    wire         isBrOvf  = fetchStrobe && instrWord[15:8] == 8'hE4;
    wire         isBrZero = fetchStrobe && instrWord[15:8] == 8'hE0;
    wire         isCall  = fetchStrobe && instrWord[15:9] == 7'h76;
    wire         isClr   = fetchStrobe && instrWord[15:9] == 7'h35;
    wire  [20:0] brOff   = {{12{fLit[7]}}, fLit, 1'b0};
    wire  [20:0] callLit = {instrWord2[11:0], fLit, 1'b0};
    wire         accIdx  = ext_q && fLow;
    wire  [11:0] accAddr = accIdx ? fsr2Base + {4'h0, fLit} : {fLow ? 4'h0 : 4'hF, fLit};
    wire         jumps   = (isBrOvf && ov_q) || (isBrZero && z_q) || isCall;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ov_q <= 1'b0;
            z_q <= 1'b0;
            ext_q <= 1'b0;
            bank_q <= 4'h0;
        end else begin
            if (regWr && regAddr == 4'h2) begin
                ov_q <= regWdata[3];
                z_q <= regWdata[2];
            end
            // A clear-register write sets Z even over a bus write in the same cycle.
            if (dataWr) begin
                z_q <= 1'b1;
            end
            if (regWr && regAddr == 4'h0) begin
                ext_q <= regWdata[0];
            end
            if (regWr && regAddr == 4'h3) begin
                bank_q <= regWdata[3:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_PC_ALIGN: assert property (progAddr[0] == 1'b0)
        else $error("program address is odd");
    AST_OVF_TAKEN: assert property (isBrOvf && ov_q |-> ##8 fetchStrobe &&
        progAddr == $past(progAddr, 8) + 21'h2 + $past(brOff, 8))
        else $error("overflow branch target wrong");
    AST_OVF_SKIP: assert property (isBrOvf && !ov_q |-> ##4 fetchStrobe &&
        progAddr == $past(progAddr, 4) + 21'h2)
        else $error("untaken overflow branch wrong");
    AST_ZERO_TAKEN: assert property (isBrZero && z_q |-> ##8 fetchStrobe &&
        progAddr == $past(progAddr, 8) + 21'h2 + $past(brOff, 8))
        else $error("zero branch target wrong");
    AST_JUMP_IDLE: assert property (jumps |=> !fetchStrobe [*7])
        else $error("fetch during idle cycle");
    AST_CALL_TARGET: assert property (isCall |-> ##8 fetchStrobe &&
        progAddr == $past(callLit, 8))
        else $error("call target wrong");
    AST_CLR_PHASES: assert property (isClr |=> dataRd && !dataWr ##1
        !dataRd && !dataWr ##1 dataWr && !dataRd && dataWdata == 8'h00)
        else $error("clear register phases wrong");
    AST_CLR_BANKED: assert property (isClr && instrWord[8] |=> !indexedMode &&
        dataAddr == {$past(bank_q), $past(fLit)})
        else $error("banked address wrong");
    AST_CLR_ACCESS: assert property (isClr && !instrWord[8] |=>
        indexedMode == $past(accIdx) && dataAddr == $past(accAddr))
        else $error("access or indexed address wrong");
    AST_WDOG_CLEAR: assert property (fetchStrobe && instrWord == 16'h0004 |-> ##3
        timeoutFlag && powerdownFlag ##1 !wdogTimeout [*8])
        else $error("watchdog clear wrong");
endmodule

bind bcce_core bcce_core_props #(.WD_CNT_W(WD_CNT_W), .WD_POST_W(WD_POST_W)) u_props (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .progAddr(progAddr),
    .fetchStrobe(fetchStrobe), .instrWord(instrWord), .instrWord2(instrWord2),
    .dataAddr(dataAddr), .dataRd(dataRd), .dataWr(dataWr), .dataWdata(dataWdata),
    .indexedMode(indexedMode), .fsr2Base(fsr2Base), .sleepEntry(sleepEntry),
    .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .wdogTimeout(wdogTimeout));

// >>> dv/branch_call_clear_exec_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module branch_call_clear_exec_bench;
    localparam int LIMIT = 4000;
    logic        clk_sys, sys_rst, regWr, regRd, sleepEntry;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata, rv;
    logic [20:0] progAddr;
    logic [11:0] dataAddr, fsr2Base;
    logic [7:0]  dataWdata;
    logic        fetchStrobe, dataRd, dataWr, indexedMode;
    logic        timeoutFlag, powerdownFlag, wdogTimeout;
    logic [15:0] prog [128];
    logic [20:0] fA [$];
    int          fC [$];
    int          cyc, n_tests, n_mismatch;
    // Program memory aliases every 256 bytes, so far call targets land in it too.
    wire  [15:0] instrWord  = prog[progAddr[7:1]];
    wire  [15:0] instrWord2 = prog[progAddr[7:1] + 7'h01];

    bcce_core #(.WD_CNT_W(2), .WD_POST_W(2)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .progAddr(progAddr),
        .fetchStrobe(fetchStrobe), .instrWord(instrWord), .instrWord2(instrWord2),
        .dataAddr(dataAddr), .dataRd(dataRd), .dataWr(dataWr), .dataWdata(dataWdata),
        .indexedMode(indexedMode), .fsr2Base(fsr2Base), .sleepEntry(sleepEntry),
        .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .wdogTimeout(wdogTimeout));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (!sys_rst && fetchStrobe) begin
            fA.push_back(progAddr);
            fC.push_back(cyc);
        end
        if (cyc == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        rv = regRdata;
        @(posedge clk_sys);
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        fA.delete();
        fC.delete();
    endtask

    task automatic wait_fetch(input logic [20:0] a);
        int k;
        k = 0;
        @(negedge clk_sys);
        while (!(fetchStrobe && progAddr == a) && k < 300) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    task automatic t_branch();
        logic [4:0]  sv;
        logic [20:0] tgt;
        for (int i = 0; i < 4; i++) begin
            tgt = i[1] ? 21'h000000 : 21'h000010;
            sv = i[0] ? (i[1] ? 5'h04 : 5'h08) : (i[1] ? 5'h1B : 5'h17);
            prog[2] = i[1] ? 16'hE0FD : 16'hE405;
            do_reset();
            wr(4'h2, {27'h0, sv});
            repeat (24) @(posedge clk_sys);
            `CHK(fA[3], i[0] ? tgt : 21'h000006)
            `CHK(fC[3] - fC[2], i[0] ? 8 : 4)
            rd(4'h2);
            `CHK(rv[4:0], sv)
        end
        $display("branch test done");
    endtask

    task automatic t_call();
        foreach (prog[j]) prog[j] = 16'h0000;
        prog[2] = 16'hED10;
        prog[3] = 16'hF800;
        prog[18] = 16'hEC30;
        prog[19] = 16'h5000;
        do_reset();
        wr(4'h1, 32'hA5);
        wr(4'h3, 32'h9);
        wr(4'h2, 32'h15);
        wait_fetch(21'h100020);
        @(posedge clk_sys);
        wr(4'h1, 32'h3C);
        wr(4'h3, 32'h2);
        wr(4'h2, 32'h0A);
        repeat (16) @(posedge clk_sys);
        `CHK(fA[3], 21'h100020)
        `CHK(fC[3] - fC[2], 8)
        `CHK(fA[6], 21'h000060)
        `CHK(fC[6] - fC[5], 8)
        wr(4'h4, 32'h77);
        rd(4'h4);
        `CHK(rv, 32'hA5)
        rd(4'h5);
        `CHK(rv, 32'h15)
        rd(4'h6);
        `CHK(rv, 32'h9)
        rd(4'h8);
        `CHK(rv, 32'h00100028)
        rd(4'h9);
        `CHK(rv, 32'h2)
        $display("call test done");
    endtask

    task automatic clear_file_register_case(input logic ext, input logic acc, input logic [7:0] f,
                             input logic [11:0] ea, input logic ei);
        foreach (prog[j]) prog[j] = 16'h0000;
        prog[2] = {7'h35, acc, f};
        do_reset();
        wr(4'h0, {31'h0, ext});
        wr(4'h3, 32'h9);
        wr(4'h2, 32'h0);
        wait_fetch(21'h000004);
        @(negedge clk_sys);
        `CHK(dataAddr, ea)
        `CHK(indexedMode, ei)
        `CHK({dataRd, dataWr}, 2'b10)
        @(negedge clk_sys);
        `CHK({dataRd, dataWr}, 2'b00)
        @(negedge clk_sys);
        `CHK({dataRd, dataWr, dataWdata}, 10'h100)
        @(posedge clk_sys);
        rd(4'h2);
        `CHK(rv[4:0], 5'h04)
    endtask

    task automatic t_wdog();
        int k;
        foreach (prog[j]) prog[j] = 16'h0000;
        prog[32] = 16'h0004;
        do_reset();
        k = 0;
        while (wdogTimeout !== 1'b1 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        repeat (2) @(negedge clk_sys);
        `CHK(timeoutFlag, 1'b0)
        @(posedge clk_sys);
        sleepEntry <= 1'b1;
        @(posedge clk_sys);
        sleepEntry <= 1'b0;
        @(negedge clk_sys);
        `CHK(powerdownFlag, 1'b0)
        wait_fetch(21'h000040);
        repeat (3) @(negedge clk_sys);
        `CHK({timeoutFlag, powerdownFlag}, 2'b11)
        @(posedge clk_sys);
        rd(4'hA);
        `CHK(rv, 32'h3)
        // Counter restarted at the clear, so it has only reached three here.
        rd(4'hB);
        `CHK(rv, 32'h3)
        wr(4'hC, 32'hFF);
        rd(4'hC);
        `CHK(rv, 32'h0)
        $display("watchdog test done");
    endtask

    initial begin
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        sleepEntry = 1'b0;
        fsr2Base = 12'h100;
        cyc = 0;
        n_tests = 0;
        n_mismatch = 0;
        foreach (prog[j]) prog[j] = 16'h0000;
        @(posedge clk_sys);
        t_branch();
        t_call();
        clear_file_register_case(1'b0, 1'b0, 8'h5F, 12'h05F, 1'b0);
        clear_file_register_case(1'b0, 1'b0, 8'h60, 12'hF60, 1'b0);
        clear_file_register_case(1'b0, 1'b1, 8'h33, 12'h933, 1'b0);
        clear_file_register_case(1'b1, 1'b0, 8'h5F, 12'h15F, 1'b1);
        clear_file_register_case(1'b1, 1'b0, 8'h60, 12'hF60, 1'b0);
        $display("clear register test done");
        t_wdog();
        close_out();
    end
endmodule
